// ---- hdl/ulbc_pkg.sv ----
// Constants and carrier types for the UART line and break control block
`default_nettype none
package ulbc_pkg;
  localparam int unsigned AW = 24;
  // Register indices; byte address is four times the index
  localparam logic [21:0] IDX_LINE = 22'h3f00b0;
  localparam logic [21:0] IDX_CTL = 22'h3f00b1;
  localparam logic [21:0] IDX_STAT = 22'h3f00b2;
  localparam logic [21:0] IDX_TXH = 22'h3f00b3;
  localparam logic [21:0] IDX_RXH = 22'h3f00b4;
  localparam logic [21:0] IDX_IST = 22'h3f00b5;
  localparam logic [21:0] IDX_MASK = 22'h3f00b6;
  localparam logic [21:0] IDX_DIV = 22'h3f00b7;
  // Reset values
  localparam logic [7:0] LINE_RST = 8'h00;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [15:0] DIV_RST = 16'h0000;
  // Field positions
  localparam int unsigned CTL_BRK = 6;
  localparam int unsigned CTL_LOOP = 7;
  localparam int unsigned ST_TXE = 7;
  localparam int unsigned ST_TBE = 6;
  localparam int unsigned ST_RDY = 5;
  localparam int unsigned ST_FRM = 2;
  localparam int unsigned ST_PAR = 1;
  localparam int unsigned ST_OVR = 0;
  localparam int unsigned IRQ_TXE = 0;
  localparam int unsigned IRQ_RDY = 1;
  localparam int unsigned IRQ_PAR = 2;
  localparam int unsigned IRQ_FRM = 3;
  localparam int unsigned IRQ_OVR = 4;
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned PAR_EN = 2;
  // Parity modes; any code with the top bit clear sends no parity
  localparam logic [2:0] PAR_ODD = 3'h4;
  localparam logic [2:0] PAR_EVEN = 3'h5;
  localparam logic [2:0] PAR_ONE = 3'h6;
  localparam logic [2:0] PAR_ZERO = 3'h7;
  // Oversampling: sixteen ticks per bit
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [2:0] FSZ_BASE = 3'h4;
  localparam logic [1:0] FSZ_MAX = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] par;
    logic stop2;
    logic [1:0] fsz;
  } ulbc_cfg_t;

  function automatic logic par_bit(input logic [2:0] mode, input logic acc);
    case (mode)
      PAR_ODD: par_bit = ~acc;
      PAR_EVEN: par_bit = acc;
      PAR_ONE: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction : par_bit
endpackage : ulbc_pkg
`default_nettype wire

// ---- hdl/ulbc_tx.sv ----
// Transmit shifter: start, data, optional parity, one or two stop bits
`default_nettype none
module ulbc_tx (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Frame request
  input wire logic i_tick,
  input wire logic i_start,
  input wire logic [7:0] i_data,
  input wire ulbc_pkg::ulbc_cfg_t i_cfg,
  // Line side
  output logic o_line,
  output logic o_busy
);
  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_START = 5'b00010,
    TX_DATA = 5'b00100,
    TX_PAR = 5'b01000,
    TX_STOP = 5'b10000
  } ulbc_tx_st_t;
  typedef struct packed {
    ulbc_tx_st_t st;
    logic [3:0] sub;
    logic [2:0] bits;
    logic [7:0] shf;
    logic acc;
    logic second;
  } ulbc_tx_t;
  ulbc_tx_t s_reg, s_next;
  logic last;

  always_comb
  begin
    s_next = s_reg;
    last = i_tick && (s_reg.sub == ulbc_pkg::OVS_LAST);
    o_line = 1'b1;
    if (i_tick)
      s_next.sub = s_reg.sub + 4'h1;
    case (s_reg.st)
      TX_IDLE:
      begin
        s_next.sub = 4'h0;
        if (i_start)
        begin
          s_next = '{st: TX_START, shf: i_data, default: '0};
        end
      end
      TX_START:
      begin
        o_line = 1'b0;
        if (last)
          s_next.st = TX_DATA;
      end
      TX_DATA:
      begin
        o_line = s_reg.shf[0];
        if (last)
        begin
          s_next.acc = s_reg.acc ^ s_reg.shf[0];
          s_next.shf = {1'b0, s_reg.shf[7:1]};
          s_next.bits = s_reg.bits + 3'h1;
          if (s_reg.bits == ulbc_pkg::FSZ_BASE + {1'b0, i_cfg.fsz})
            s_next.st = i_cfg.par[ulbc_pkg::PAR_EN] ? TX_PAR : TX_STOP;
        end
      end
      TX_PAR:
      begin
        o_line = ulbc_pkg::par_bit(i_cfg.par, s_reg.acc);
        if (last)
          s_next.st = TX_STOP;
      end
      TX_STOP:
      begin
        if (last)
        begin
          if (i_cfg.stop2 && !s_reg.second)
            s_next.second = 1'b1;
          else
            s_next.st = TX_IDLE;
        end
      end
      default: s_next.st = TX_IDLE;
    endcase
    o_busy = (s_reg.st != TX_IDLE);
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      s_reg <= '{st: TX_IDLE, default: '0};
    else
      s_reg <= s_next;
  end

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  AST_STOP_TWO: assert property (
    (s_reg.st == TX_STOP) && last && i_cfg.stop2 && !s_reg.second |=> s_reg.st == TX_STOP)
    else $error("second stop bit skipped");
  AST_STOP_ONE: assert property (
    (s_reg.st == TX_STOP) && last && !i_cfg.stop2 |=> s_reg.st == TX_IDLE)
    else $error("extra stop bit sent");
  AST_WORD_LEN: assert property (
    (s_reg.st == TX_DATA) && last && (s_reg.bits == ulbc_pkg::FSZ_BASE + {1'b0, i_cfg.fsz})
    |=> s_reg.st != TX_DATA)
    else $error("wrong data bit count");
endmodule : ulbc_tx
`default_nettype wire

// ---- hdl/ulbc_rx.sv ----
// Receive shifter: 16x sampled, parity check and stop check
`default_nettype none
module ulbc_rx (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // Line side
  input wire logic i_tick,
  input wire logic i_rxd,
  input wire ulbc_pkg::ulbc_cfg_t i_cfg,
  // Received frame
  output logic o_valid,
  output logic [7:0] o_data,
  output logic o_perr,
  output logic o_ferr
);
  typedef enum logic [4:0] {
    RX_IDLE = 5'b00001,
    RX_START = 5'b00010,
    RX_DATA = 5'b00100,
    RX_PAR = 5'b01000,
    RX_STOP = 5'b10000
  } ulbc_rx_st_t;
  typedef struct packed {
    ulbc_rx_st_t st;
    logic [3:0] sub;
    logic [2:0] bits;
    logic [7:0] shf;
    logic acc;
    logic valid;
    logic [7:0] data;
    logic perr;
    logic ferr;
  } ulbc_rx_t;
  ulbc_rx_t s_reg, s_next;
  logic last;

  always_comb
  begin
    s_next = s_reg;
    s_next.valid = 1'b0;
    last = i_tick && (s_reg.sub == ulbc_pkg::OVS_LAST);
    if (i_tick)
      s_next.sub = s_reg.sub + 4'h1;
    case (s_reg.st)
      RX_IDLE:
      begin
        s_next.sub = 4'h0;
        if (!i_rxd)
          s_next.st = RX_START;
      end
      RX_START:
      begin
        if (i_tick && (s_reg.sub == ulbc_pkg::OVS_MID))
        begin
          s_next.sub = 4'h0;
          s_next.bits = 3'h0;
          s_next.acc = 1'b0;
          s_next.perr = 1'b0;
          s_next.st = i_rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA:
      begin
        if (last)
        begin
          s_next.shf = {i_rxd, s_reg.shf[7:1]};
          s_next.acc = s_reg.acc ^ i_rxd;
          s_next.bits = s_reg.bits + 3'h1;
          if (s_reg.bits == ulbc_pkg::FSZ_BASE + {1'b0, i_cfg.fsz})
            s_next.st = i_cfg.par[ulbc_pkg::PAR_EN] ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR:
      begin
        if (last)
        begin
          s_next.perr = (i_rxd != ulbc_pkg::par_bit(i_cfg.par, s_reg.acc));
          s_next.st = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (last)
        begin
          s_next.ferr = !i_rxd;
          s_next.valid = 1'b1;
          s_next.data = s_reg.shf >> (ulbc_pkg::FSZ_MAX - i_cfg.fsz);
          s_next.st = RX_IDLE;
        end
      end
      default: s_next.st = RX_IDLE;
    endcase
    o_valid = s_reg.valid;
    o_data = s_reg.data;
    o_perr = s_reg.perr;
    o_ferr = s_reg.ferr;
  end

  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      s_reg <= '{st: RX_IDLE, default: '0};
    else
      s_reg <= s_next;
  end
endmodule : ulbc_rx
`default_nettype wire

// ---- hdl/ulbc_top.sv ----
// UART line format, loopback and break control with AXI4-Lite registers
// Overview of operation
// - Line control bit 2 clear sends one stop bit, set sends two.
// - Line control bits 1:0 choose 5, 6, 7 or 8 data bits.
// - Line control bits 5:3 choose parity generation and checking, five options.
// - Control bit 7: transmit pin held high, transmitter looped into receiver.
// - Control bit 6 drives the transmit pin continuously low as a break, unless control bit 7 is also set.
// - During break the frame still shifts internally, so empty flag times it.
// - Transmitter empty flag set when holding register and shifter are empty.
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
module ulbc_top (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // AXI4-Lite write address and data
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [ulbc_pkg::AW-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [ulbc_pkg::AW-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Serial line
  input wire logic i_rxd,
  output logic o_txd,
  // Interrupt
  output logic o_irq
);
  typedef struct packed {
    logic [1:0] sync;
    logic [7:0] line;
    logic [7:0] ctl;
    logic [7:0] txh;
    logic [7:0] rxh;
    logic [7:0] mask;
    logic [ulbc_pkg::IRQ_W-1:0] ist;
    logic [15:0] div;
    logic [15:0] baud;
    logic tick;
    logic txh_full;
    logic start;
    logic txe_d;
    logic rx_rdy;
    logic perr;
    logic ferr;
    logic ovr;
    logic txo;
    logic aw_ok;
    logic w_ok;
    logic [21:0] widx;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ulbc_top_t;
  ulbc_top_t s_reg, s_next;

  ulbc_pkg::ulbc_cfg_t cfg;
  logic tx_line, tx_busy, rx_in, rx_valid, rx_perr, rx_ferr, txe, wr_go, rd_go;
  logic [7:0] rx_data, stat;
  logic [21:0] ridx;
  logic [ulbc_pkg::IRQ_W-1:0] ev, w1c;

  assign cfg = ulbc_pkg::ulbc_cfg_t'(s_reg.line[5:0]);

  // ==========================================================================
  // Shifters
  ulbc_tx u_tx (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(s_reg.tick),
    .i_start(s_reg.start),
    .i_data(s_reg.txh),
    .i_cfg(cfg),
    .o_line(tx_line),
    .o_busy(tx_busy)
  );

  ulbc_rx u_rx (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_tick(s_reg.tick),
    .i_rxd(rx_in),
    .i_cfg(cfg),
    .o_valid(rx_valid),
    .o_data(rx_data),
    .o_perr(rx_perr),
    .o_ferr(rx_ferr)
  );

  // ==========================================================================
  // Next state
  always_comb
  begin
    s_next = s_reg;
    rx_in = s_reg.ctl[ulbc_pkg::CTL_LOOP] ? tx_line : s_reg.sync[1];
    // empty flag follows the shifter, break or not
    txe = !s_reg.txh_full && !tx_busy && !s_reg.start;
    stat = 8'h00;
    stat[ulbc_pkg::ST_TXE] = txe;
    stat[ulbc_pkg::ST_TBE] = !s_reg.txh_full;
    stat[ulbc_pkg::ST_RDY] = s_reg.rx_rdy;
    stat[ulbc_pkg::ST_FRM] = s_reg.ferr;
    stat[ulbc_pkg::ST_PAR] = s_reg.perr;
    stat[ulbc_pkg::ST_OVR] = s_reg.ovr;
    s_next.sync = {s_reg.sync[0], i_rxd};

    // Baud tick at sixteen times the bit rate
    s_next.tick = (s_reg.baud >= s_reg.div);
    s_next.baud = s_next.tick ? 16'h0000 : s_reg.baud + 16'h0001;

    // Holding register to shifter
    s_next.start = 1'b0;
    if (s_reg.txh_full && !tx_busy && !s_reg.start)
    begin
      s_next.start = 1'b1;
      s_next.txh_full = 1'b0;
    end

    // pin drive; loopback wins over break
    if (s_reg.ctl[ulbc_pkg::CTL_LOOP])
      s_next.txo = 1'b1;
    else if (s_reg.ctl[ulbc_pkg::CTL_BRK])
      s_next.txo = 1'b0;
    else
      s_next.txo = tx_line;

    // Bus handshakes
    o_awready = !s_reg.aw_ok && !s_reg.bvalid;
    o_wready = !s_reg.w_ok && !s_reg.bvalid;
    o_arready = !s_reg.rvalid;
    if (i_awvalid && o_awready)
    begin
      s_next.aw_ok = 1'b1;
      s_next.widx = i_awaddr[ulbc_pkg::AW-1:2];
    end
    if (i_wvalid && o_wready)
    begin
      s_next.w_ok = 1'b1;
      s_next.wdata = i_wdata;
      s_next.wstrb = i_wstrb;
    end
    if (s_reg.bvalid && i_bready)
      s_next.bvalid = 1'b0;

    // Register writes
    wr_go = s_reg.aw_ok && s_reg.w_ok && !s_reg.bvalid;
    w1c = '0;
    if (wr_go)
    begin
      s_next.aw_ok = 1'b0;
      s_next.w_ok = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = ulbc_pkg::RESP_OKAY;
      case (s_reg.widx)
        ulbc_pkg::IDX_LINE: if (s_reg.wstrb[0]) s_next.line = s_reg.wdata[7:0];
        ulbc_pkg::IDX_CTL: if (s_reg.wstrb[0]) s_next.ctl = s_reg.wdata[7:0];
        ulbc_pkg::IDX_TXH:
        begin
          if (s_reg.wstrb[0])
          begin
            s_next.txh = s_reg.wdata[7:0];
            s_next.txh_full = 1'b1;
          end
        end
        ulbc_pkg::IDX_IST: if (s_reg.wstrb[0]) w1c = s_reg.wdata[ulbc_pkg::IRQ_W-1:0];
        ulbc_pkg::IDX_MASK: if (s_reg.wstrb[0]) s_next.mask = s_reg.wdata[7:0];
        ulbc_pkg::IDX_DIV:
        begin
          if (s_reg.wstrb[0]) s_next.div[7:0] = s_reg.wdata[7:0];
          if (s_reg.wstrb[1]) s_next.div[15:8] = s_reg.wdata[15:8];
        end
        ulbc_pkg::IDX_STAT, ulbc_pkg::IDX_RXH: ;
        default: s_next.bresp = ulbc_pkg::RESP_SLVERR;
      endcase
    end

    // Register reads; reading received data frees it
    ridx = i_araddr[ulbc_pkg::AW-1:2];
    rd_go = i_arvalid && o_arready;
    if (s_reg.rvalid && i_rready)
      s_next.rvalid = 1'b0;
    if (rd_go)
    begin
      s_next.rvalid = 1'b1;
      s_next.rresp = ulbc_pkg::RESP_OKAY;
      s_next.rdata = 32'h0000_0000;
      case (ridx)
        ulbc_pkg::IDX_LINE: s_next.rdata[7:0] = s_reg.line;
        ulbc_pkg::IDX_CTL: s_next.rdata[7:0] = s_reg.ctl;
        ulbc_pkg::IDX_STAT: s_next.rdata[7:0] = stat;
        ulbc_pkg::IDX_TXH: s_next.rdata[7:0] = s_reg.txh;
        ulbc_pkg::IDX_RXH:
        begin
          s_next.rdata[7:0] = s_reg.rxh;
          s_next.rx_rdy = 1'b0;
        end
        ulbc_pkg::IDX_IST: s_next.rdata[ulbc_pkg::IRQ_W-1:0] = s_reg.ist;
        ulbc_pkg::IDX_MASK: s_next.rdata[7:0] = s_reg.mask;
        ulbc_pkg::IDX_DIV: s_next.rdata[15:0] = s_reg.div;
        default: s_next.rresp = ulbc_pkg::RESP_SLVERR;
      endcase
    end

    // Received frame; arrival wins over a read that frees the register
    if (rx_valid)
    begin
      s_next.ovr = s_reg.rx_rdy && !(rd_go && ridx == ulbc_pkg::IDX_RXH);
      s_next.rxh = rx_data;
      s_next.rx_rdy = 1'b1;
      s_next.perr = rx_perr;
      s_next.ferr = rx_ferr;
    end

    // Sticky events, set wins over clear
    s_next.txe_d = txe;
    ev = '0;
    ev[ulbc_pkg::IRQ_TXE] = txe && !s_reg.txe_d;
    ev[ulbc_pkg::IRQ_RDY] = rx_valid;
    ev[ulbc_pkg::IRQ_PAR] = rx_valid && rx_perr;
    ev[ulbc_pkg::IRQ_FRM] = rx_valid && rx_ferr;
    ev[ulbc_pkg::IRQ_OVR] = rx_valid && s_next.ovr;
    s_next.ist = (s_reg.ist & ~w1c) | ev;

    o_bvalid = s_reg.bvalid;
    o_bresp = s_reg.bresp;
    o_rvalid = s_reg.rvalid;
    o_rdata = s_reg.rdata;
    o_rresp = s_reg.rresp;
    o_txd = s_reg.txo;
    o_irq = |(s_reg.ist & s_reg.mask[ulbc_pkg::IRQ_W-1:0]);
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_core_clk)
  begin
    if (!i_rst_n)
      s_reg <= '{line: ulbc_pkg::LINE_RST, ctl: ulbc_pkg::CTL_RST,
                 mask: ulbc_pkg::MASK_RST, div: ulbc_pkg::DIV_RST,
                 sync: 2'h3, txo: 1'b1, txe_d: 1'b1, default: '0};
    else
      s_reg <= s_next;
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_brk_frame_start;
    s_reg.ctl[ulbc_pkg::CTL_BRK] && txe ##1 s_reg.txh_full;
  endsequence

  AST_LOOP_HIGH: assert property (
    s_reg.ctl[ulbc_pkg::CTL_LOOP] |=> o_txd)
    else $error("loopback did not hold pin high");
  AST_LOOP_ROUTE: assert property (
    s_reg.ctl[ulbc_pkg::CTL_LOOP] |-> rx_in == tx_line)
    else $error("loopback path broken");
  AST_BREAK_LOW: assert property (
    s_reg.ctl[ulbc_pkg::CTL_BRK] && !s_reg.ctl[ulbc_pkg::CTL_LOOP] |=> !o_txd)
    else $error("break not driven low");
  AST_BREAK_SHIFTS: assert property (
    s_brk_frame_start |=> !txe ##1 (tx_busy && !txe)[*2])
    else $error("frame not shifted during break");
  AST_TXE_FLAG: assert property (
    s_reg.rvalid && $past(rd_go) && $past(ridx) == ulbc_pkg::IDX_STAT
    |-> s_reg.rdata[ulbc_pkg::ST_TXE] == $past(txe))
    else $error("empty flag misreported");
  AST_TXE_CLEAR: assert property (
    wr_go && s_reg.widx == ulbc_pkg::IDX_TXH && s_reg.wstrb[0] |=> !txe)
    else $error("empty flag stayed set after write");
  AST_EVENT_WINS: assert property (
    rx_valid |=> s_reg.ist[ulbc_pkg::IRQ_RDY] && s_reg.rx_rdy)
    else $error("receive event lost");
  AST_WRITE_RESP: assert property (
    wr_go |=> s_reg.bvalid ##0 !s_reg.aw_ok && !s_reg.w_ok)
    else $error("write response missing");
endmodule : ulbc_top
`default_nettype wire

// ---- tb/ulbc_peer.sv ----
// Remote serial peer: sends frames into the receiver, decodes frames from the transmitter
`default_nettype none
module ulbc_peer #(
  parameter int BT = 16
) (
  // Clock
  input wire logic i_clk,
  // Serial line
  input wire logic i_txd,
  output logic o_rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial o_rxd = 1'b1;

  function automatic logic pbit(input logic [2:0] pm, input logic acc);
    case (pm)
      ulbc_pkg::PAR_ODD: pbit = ~acc;
      ulbc_pkg::PAR_EVEN: pbit = acc;
      ulbc_pkg::PAR_ONE: pbit = 1'b1;
      default: pbit = 1'b0;
    endcase
  endfunction : pbit

  task automatic bit_out(input logic b);
    @(posedge i_clk);
    o_rxd <= b;
    repeat (BT - 1) @(posedge i_clk);
  endtask : bit_out

  // ==========================================
  // Frame sender
  // start, data, parity, stops
  task automatic send(input logic [7:0] d, input logic [2:0] pm, input logic [1:0] fsz,
                      input logic s2, input logic pbad, input logic sbad);
    logic acc;
    acc = ^(d & (8'hff >> (2'h3 - fsz)));
    bit_out(1'b0);
    for (int i = 0; i <= int'(fsz) + 4; i++)
      bit_out(d[i]);
    if (pm[2])
      bit_out(pbit(pm, acc) ^ pbad);
    bit_out(~sbad);
    if (s2)
      bit_out(1'b1);
    bit_out(1'b1);
  endtask : send

  // ==========================================
  // Frame decoder, samples mid-bit
  // LSB first, frame size 5 to 8
  task automatic recv(input logic [2:0] pm, input logic [1:0] fsz, output logic [7:0] d,
                      output logic p, output logic [1:0] st);
    int n;
    n = 0;
    d = 8'h00;
    p = 1'b0;
    while (i_txd !== 1'b0 && n < 5000)
    begin
      @(posedge i_clk);
      n++;
    end
    repeat (BT / 2) @(posedge i_clk);
    for (int i = 0; i <= int'(fsz) + 4; i++)
    begin
      repeat (BT) @(posedge i_clk);
      d[i] = i_txd;
    end
    if (pm[2])
    begin
      repeat (BT) @(posedge i_clk);
      p = i_txd;
    end
    repeat (BT) @(posedge i_clk);
    st[0] = i_txd;
    repeat (BT) @(posedge i_clk);
    st[1] = i_txd;
  endtask : recv
endmodule : ulbc_peer
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the UART line and break control block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst_n, awvalid, wvalid, bready, arvalid, rready, rxd, txd, irq;
  logic awready, wready, bvalid, arready, rvalid, mon_on, mon_lvl, gp, s2;
  logic [23:0] awaddr, araddr;
  logic [31:0] wdata, rdata, seed, v, x;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r, gs, fsz;
  logic [7:0] d, d2, gd, m;
  logic [2:0] pm;
  logic [2:0] modes [5] = '{3'h0, ulbc_pkg::PAR_ODD, ulbc_pkg::PAR_EVEN,
                           ulbc_pkg::PAR_ONE, ulbc_pkg::PAR_ZERO};
  int bad_count, total_checks, mon_bad, cyc;
  time t0;

  always #25 core_clk = ~core_clk;

  ulbc_top i_ulbc_top (.i_core_clk(core_clk), .i_rst_n(rst_n), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
    .i_rxd(rxd), .o_txd(txd), .o_irq(irq));
  ulbc_peer i_ulbc_peer (.i_clk(core_clk), .i_txd(txd), .o_rxd(rxd));

  always @(posedge core_clk)
    if (mon_on && txd !== mon_lvl)
      mon_bad++;

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] wmask(input logic [1:0] w);
    return 8'hff >> (2'h3 - w);
  endfunction : wmask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  task automatic test_done();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  // ==========================================
  // Register bus
  task automatic wr(input logic [21:0] idx, input logic [31:0] dat, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge core_clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= {idx, 2'b00};
    wdata <= dat;
    bready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
    end while (!bvalid && n < 300);
    rs = bresp;
    bready <= 1'b0;
    chk("write answer", 32'h1, {31'h0, bvalid});
  endtask : wr

  task automatic rd(input logic [21:0] idx, output logic [31:0] dat, output logic [1:0] rs);
    int n;
    n = 0;
    @(posedge core_clk);
    arvalid <= 1'b1;
    araddr <= {idx, 2'b00};
    rready <= 1'b1;
    do
    begin
      @(posedge core_clk);
      n++;
      if (arvalid && arready)
        arvalid <= 1'b0;
    end while (!rvalid && n < 300);
    dat = rdata;
    rs = rresp;
    rready <= 1'b0;
    chk("read answer", 32'h1, {31'h0, rvalid});
  endtask : rd

  task automatic wreg(input logic [21:0] idx, input logic [31:0] dat);
    logic [1:0] rs;
    wr(idx, dat, rs);
    chk("write resp", ulbc_pkg::RESP_OKAY, rs);
  endtask : wreg

  task automatic rreg(input logic [21:0] idx, output logic [31:0] dat);
    logic [1:0] rs;
    rd(idx, dat, rs);
    chk("read resp", ulbc_pkg::RESP_OKAY, rs);
  endtask : rreg

  task automatic poll(input int pos);
    logic [31:0] s;
    s = 32'h0;
    for (int n = 0; n < 400 && !s[pos]; n++)
      rreg(ulbc_pkg::IDX_STAT, s);
    chk("status poll", 32'h1, {31'h0, s[pos]});
  endtask : poll

  // ==========================================
  // Main sequence
  initial
  begin
    {bad_count, total_checks, mon_bad} = '0;
    seed = 32'h0000fc70;
    {rst_n, awvalid, wvalid, bready, arvalid, rready, mon_on, mon_lvl} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hf;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    rreg(ulbc_pkg::IDX_LINE, v);
    chk("line reset", ulbc_pkg::LINE_RST, v);
    rreg(ulbc_pkg::IDX_CTL, v);
    chk("control reset", ulbc_pkg::CTL_RST, v);
    rreg(ulbc_pkg::IDX_STAT, v);
    chk("status reset", 32'hc0, v);
    rreg(ulbc_pkg::IDX_MASK, v);
    chk("mask reset", ulbc_pkg::MASK_RST, v);
    rreg(ulbc_pkg::IDX_DIV, v);
    chk("divisor reset", ulbc_pkg::DIV_RST, v);
    rd(22'h3f00b8, v, r);
    chk("unmapped read", ulbc_pkg::RESP_SLVERR, r);
    wr(22'h3f00b8, 32'hff, r);
    chk("unmapped write", ulbc_pkg::RESP_SLVERR, r);
    for (int k = 0; k < 10; k++)
    begin
      x = rnd();
      pm = modes[k % 5];
      fsz = k[1:0];
      s2 = x[8];
      d = x[7:0];
      d2 = x[23:16];
      m = wmask(fsz);
      wreg(ulbc_pkg::IDX_LINE, {26'h0, pm, s2, fsz});
      rreg(ulbc_pkg::IDX_LINE, v);
      chk("line readback", {26'h0, pm, s2, fsz}, v);
      wreg(ulbc_pkg::IDX_MASK, {30'h0, k == 0, 1'b0});
      fork
        i_ulbc_peer.recv(pm, fsz, gd, gp, gs);
        begin
          wreg(ulbc_pkg::IDX_TXH, {24'h0, d});
          poll(ulbc_pkg::ST_TBE);
          wreg(ulbc_pkg::IDX_TXH, {24'h0, d2});
        end
      join
      chk("tx data", d & m, gd);
      if (pm[2])
        chk("tx parity", i_ulbc_peer.pbit(pm, ^(d & m)), gp);
      chk("tx stops", {s2, 1'b1}, gs);
      poll(ulbc_pkg::ST_TXE);
      i_ulbc_peer.send(d2, pm, fsz, s2, k == 7, k == 9);
      // Second frame before the first is read
      if (k == 8)
        i_ulbc_peer.send(d2, pm, fsz, s2, 1'b0, 1'b0);
      poll(ulbc_pkg::ST_RDY);
      rreg(ulbc_pkg::IDX_STAT, v);
      if (k < 7)
        chk("rx errors", 32'h0, v[2:0]);
      if (k == 7)
        chk("parity error", 32'h1, v[ulbc_pkg::ST_PAR]);
      if (k == 8)
        chk("overrun", 32'h1, v[ulbc_pkg::ST_OVR]);
      if (k == 9)
        chk("frame error", 32'h1, v[ulbc_pkg::ST_FRM]);
      chk("irq", k == 0, irq);
      wreg(ulbc_pkg::IDX_IST, 32'h1f);
      chk("irq cleared", 32'h0, irq);
      rreg(ulbc_pkg::IDX_RXH, v);
      chk("rx data", d2 & m, v);
    end
    // Divisor lanes, then back to full rate
    wreg(ulbc_pkg::IDX_DIV, {16'h0, x[15:0]});
    rreg(ulbc_pkg::IDX_DIV, v);
    chk("divisor", {16'h0, x[15:0]}, v);
    wreg(ulbc_pkg::IDX_DIV, 32'h0);
    // Break timed by the empty flag
    wreg(ulbc_pkg::IDX_LINE, {26'h0, ulbc_pkg::PAR_EVEN, 1'b1, 2'h3});
    rreg(ulbc_pkg::IDX_STAT, v);
    chk("empty before break", 32'h1, v[ulbc_pkg::ST_TXE]);
    wreg(ulbc_pkg::IDX_CTL, 32'h40);
    repeat (2) @(posedge core_clk);
    chk("break level", 32'h0, txd);
    mon_lvl = 1'b0;
    mon_on = 1'b1;
    wreg(ulbc_pkg::IDX_TXH, {24'h0, d});
    t0 = $time;
    rreg(ulbc_pkg::IDX_STAT, v);
    chk("empty in break", 32'h0, v[ulbc_pkg::ST_TXE]);
    poll(ulbc_pkg::ST_TXE);
    cyc = int'(($time - t0) / 50);
    mon_on = 1'b0;
    chk("break span", 32'h1, cyc >= 192 && cyc <= 204);
    chk("break held", 32'h0, mon_bad);
    wreg(ulbc_pkg::IDX_CTL, 32'h0);
    repeat (2) @(posedge core_clk);
    chk("idle after break", 32'h1, txd);
    // Loopback, also with break set
    mon_lvl = 1'b1;
    mon_on = 1'b1;
    wreg(ulbc_pkg::IDX_CTL, 32'hc0);
    wreg(ulbc_pkg::IDX_TXH, {24'h0, d2});
    poll(ulbc_pkg::ST_RDY);
    mon_on = 1'b0;
    chk("loop line high", 32'h0, mon_bad);
    rreg(ulbc_pkg::IDX_RXH, v);
    chk("loop data", d2, v);
    test_done();
  end

  initial
  begin
    repeat (40000) @(posedge core_clk);
    bad_count++;
    $display("unexpected watchdog: expected finish, seen timeout");
    test_done();
  end
endmodule : tb_top
`default_nettype wire
